/* File: dv/oaf_checker_asserts.sv */
// Port-level checker for the operand fetch and address sequencer
`timescale 1ns/1ps
module oaf_checker
	import opfetch_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [opfetch_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [opfetch_pkg::ADDR_W-1:0] pc,
	input wire logic [opfetch_pkg::ADDR_W-1:0] eff_addr,
	input wire logic eff_valid,
	input wire logic [2:0] cur_mode
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// ********************
	// Properties
	// ********************
	property p_eff_pulse;
		eff_valid |=> !eff_valid;
	endproperty
	property p_wr_pulse;
		mem_wr |=> !mem_wr;
	endproperty
	property p_dir_hi;
		eff_valid && cur_mode == 3'd3 |-> eff_addr[15:8] == ZERO_PAGE_HI;
	endproperty
	property p_eff_mode;
		eff_valid |-> cur_mode inside {3'd3, 3'd4};
	endproperty
	property p_wr_at_eff;
		mem_wr |-> mem_addr == eff_addr;
	endproperty
	// Jumps load the formed address, every other change is one byte on
	property p_pc_step;
		$changed(pc) |-> pc == $past(pc) + PC_STEP || pc == eff_addr;
	endproperty
	property p_eff_hold;
		!eff_valid |-> $stable(eff_addr);
	endproperty
	property p_rd_at_eff;
		eff_valid && mem_rd |-> mem_addr == eff_addr;
	endproperty
	a_eff_pulse: assert property (p_eff_pulse)
		else $error("eff_valid held past one cycle");
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("mem_wr held past one cycle");
	a_dir_hi: assert property (p_dir_hi)
		else $error("direct address upper byte not zero");
	a_eff_mode: assert property (p_eff_mode)
		else $error("address formed outside direct or extended");
	a_wr_at_eff: assert property (p_wr_at_eff)
		else $error("write away from effective address");
	a_pc_step: assert property (p_pc_step)
		else $error("pc moved by other than one byte");
	a_eff_hold: assert property (p_eff_hold)
		else $error("eff_addr changed without eff_valid");
	a_rd_at_eff: assert property (p_rd_at_eff)
		else $error("operand read away from effective address");
	c_dir: cover property (eff_valid && cur_mode == 3'd3);
	c_ext: cover property (eff_valid && cur_mode == 3'd4);
	c_wr: cover property (mem_wr);
endmodule
bind operand_address_formation oaf_checker u_oaf_checker (.sys_clk(sys_clk), .resetn(resetn),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .pc(pc), .eff_addr(eff_addr),
	.eff_valid(eff_valid), .cur_mode(cur_mode));

/* File: dv/prog_mem.sv */
// Program and data memory facing the sequencer: combinational read, write on sys_clk
`timescale 1ns/1ps
module prog_mem
	import opfetch_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [opfetch_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [opfetch_pkg::DATA_W-1:0] mem_wdata,
	output logic [opfetch_pkg::DATA_W-1:0] mem_rdata
);
	logic [DATA_W-1:0] mem [0:65535];
	// Fill with the idle opcode so a runaway fetch stays defined
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h9D;
	end
	// Byte at mem_addr shown at all times; mem_rd only qualifies it
	assign mem_rdata = mem[mem_addr];
	always @(posedge sys_clk)
	begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
endmodule

/* File: dv/tb.sv */
// Self-checking testbench for the operand fetch and address sequencer
`timescale 1ns/1ps
module tb;
	import opfetch_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] mem_addr, pc, eff_addr;
	logic [DATA_W-1:0] mem_rdata, mem_wdata, acc, index_x;
	logic mem_rd, mem_wr, flag_z, flag_n, eff_valid, illegal_op;
	logic [2:0] cur_mode;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] prog_bytes [22] = '{8'hA6, 8'h02, 8'h4C, 8'hB6, 8'h50, 8'hC6, 8'h06, 8'hE5,
		8'h4C, 8'hA6, 8'h5A, 8'hB7, 8'h60, 8'hC7, 8'h12, 8'h34, 8'hBE, 8'h70, 8'hA7,
		8'hCC, 8'h00, 8'h40};
	always #20 sys_clk = ~sys_clk;
	operand_address_formation u_operand_address_formation (.sys_clk(sys_clk), .resetn(resetn),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .pc(pc), .acc(acc), .index_x(index_x), .flag_z(flag_z),
		.flag_n(flag_n), .eff_addr(eff_addr), .eff_valid(eff_valid), .cur_mode(cur_mode),
		.illegal_op(illegal_op));
	prog_mem u_prog_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// ********************
	// Shared tasks
	// ********************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic t_imm(input logic [7:0] val, input logic [15:0] npc);
		step(2);
		check(acc, val, "imm acc");
		check(pc, npc, "imm pc");
		check(cur_mode, 3'h2, "imm mode");
		$display("immediate load done");
	endtask
	task automatic t_inc(input logic [7:0] val, input logic z, input logic [15:0] npc);
		step(3);
		check(acc, val, "inc acc");
		check(flag_z, z, "inc zero flag");
		check(pc, npc, "inc pc");
		$display("inherent increment done");
	endtask
	task automatic t_dir_ext;
		step(4);
		check(acc, 8'h80, "direct acc");
		check(flag_n, 1'b1, "direct sign flag");
		check(eff_addr, 16'h0050, "direct address");
		check(pc, 16'h0005, "direct pc");
		step(5);
		check(acc, 8'hFF, "extended acc");
		check(eff_addr, 16'h06E5, "extended address");
		check(pc, 16'h0008, "extended pc");
		$display("direct and extended loads done");
	endtask
	task automatic t_stores;
		// Write strobe leaves on the third edge; memory takes it on the fourth
		step(4);
		check(u_prog_mem.mem[16'h0060], 8'h5A, "direct store");
		step(5);
		check(u_prog_mem.mem[16'h1234], 8'h5A, "extended store");
		check(pc, 16'h0010, "store pc");
		step(4);
		check(index_x, 8'h3C, "direct index load");
		check(pc, 16'h0012, "index load pc");
		$display("stores and index load done");
	endtask
	task automatic t_refuse_jump;
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (illegal_op === 1'b1)
				seen = 1'b1;
			step(1);
		end
		check(seen, 1'b1, "immediate store refused");
		for (int i = 0; i < 12 && pc !== 16'h0040; i++)
			step(1);
		check(pc, 16'h0040, "extended jump");
		step(8);
		check(u_prog_mem.mem[16'h0060], 8'h5B, "direct memory increment");
		$display("refusal, jump and memory increment done");
	endtask
	// ********************
	// Main sequence
	// ********************
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 400)
		begin
			fail_count++;
			$display("[FAIL] %0t run did not finish", $time);
			finish_test();
		end
	end
	initial
	begin
		#1;
		for (int i = 0; i < 22; i++)
			u_prog_mem.mem[i] = prog_bytes[i];
		u_prog_mem.mem[16'h0040] = 8'h3C;
		u_prog_mem.mem[16'h0041] = 8'h60;
		u_prog_mem.mem[16'h0050] = 8'h80;
		u_prog_mem.mem[16'h06E5] = 8'hFF;
		u_prog_mem.mem[16'h0070] = 8'h3C;
		repeat (12) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		t_imm(8'h02, 16'h0002);
		t_inc(8'h03, 1'b0, 16'h0003);
		t_dir_ext();
		t_inc(8'h00, 1'b1, 16'h0009);
		t_imm(8'h5A, 16'h000B);
		t_stores();
		t_refuse_jump();
		finish_test();
	end
endmodule

/* File: hw/mode_decode.sv */
// Opcode to addressing mode and length decoder
`timescale 1ns/1ps
module mode_decode
	import opfetch_pkg::*;
(
	input wire logic [7:0] opcode,
	output mode_t mode,
	output logic [1:0] length,
	output logic writes_mem,
	output logic is_rmw
);
	logic [3:0] col;
	logic [3:0] row;
	assign col = opcode[7:4];
	assign row = opcode[3:0];

	function automatic logic rmw_row(input logic [3:0] r);
		rmw_row = (r == RMW_NEG) || (r == RMW_COM) || (r == RMW_LSR) || (r == RMW_ROR)
			|| (r == RMW_ASR) || (r == RMW_LSL) || (r == RMW_ROL) || (r == RMW_DEC)
			|| (r == RMW_INC) || (r == RMW_TST) || (r == RMW_CLR);
	endfunction

	always_comb
	begin
		mode = MODE_ILLEGAL;
		writes_mem = 1'b0;
		is_rmw = 1'b0;
		case (col)
			COL_IMM:
			begin
				// Stores and jumps have no immediate form
				if ((row != OP_STA) && (row != OP_STX) && (row != OP_JMP) && (row != OP_JSR))
					mode = MODE_IMM;
			end
			COL_EXT:
			begin
				mode = MODE_EXT;
				writes_mem = (row == OP_STA) || (row == OP_STX);
			end
			COL_DIR:
			begin
				mode = MODE_DIR;
				writes_mem = (row == OP_STA) || (row == OP_STX);
			end
			COL_RMW_DIR:
			begin
				if (rmw_row(row))
				begin
					mode = MODE_DIR;
					is_rmw = 1'b1;
					writes_mem = (row != RMW_TST);
				end
			end
			COL_BIT_DIR:
			begin
				mode = MODE_DIR;
				is_rmw = 1'b1;
				writes_mem = 1'b1;
			end
			COL_BRBIT_DIR:
				mode = MODE_DIR;
			COL_INH_A, COL_INH_X:
			begin
				if (rmw_row(row) || ((col == COL_MUL) && (row == 4'h2)))
					mode = MODE_INH;
			end
			COL_INH_MISC8, COL_INH_MISC9:
				mode = MODE_INH;
			default:
				mode = MODE_ILLEGAL;
		endcase
		case (mode)
			MODE_INH: length = 2'h1;
			MODE_IMM: length = 2'h2;
			MODE_DIR: length = 2'h2;
			MODE_EXT: length = 2'h3;
			default: length = 2'h1;
		endcase
	end
endmodule

/* File: hw/operand_address_formation.sv */
// Operand fetch and effective address sequencer for four addressing modes
`timescale 1ns/1ps
module operand_address_formation
	import opfetch_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [opfetch_pkg::DATA_W-1:0] mem_rdata,
	output logic [opfetch_pkg::ADDR_W-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [opfetch_pkg::DATA_W-1:0] mem_wdata,
	output logic [opfetch_pkg::ADDR_W-1:0] pc,
	output logic [opfetch_pkg::DATA_W-1:0] acc,
	output logic [opfetch_pkg::DATA_W-1:0] index_x,
	output logic flag_z,
	output logic flag_n,
	output logic [opfetch_pkg::ADDR_W-1:0] eff_addr,
	output logic eff_valid,
	output logic [2:0] cur_mode,
	output logic illegal_op
);
	import opfetch_pkg::*;

	// ****************************************
	// State
	// ****************************************
	fetch_state_t state_reg, state_next;
	logic [15:0] pc_reg, pc_next;
	logic [7:0] op_reg, op_next;
	logic [7:0] hi_reg, hi_next;
	logic [7:0] lo_reg, lo_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] x_reg, x_next;
	logic z_reg, z_next;
	logic n_reg, n_next;
	logic [15:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic wr_reg, wr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [15:0] ea_reg, ea_next;
	logic eav_reg, eav_next;
	logic [2:0] mode_reg, mode_next;
	logic ill_reg, ill_next;

	mode_t dec_mode;
	logic [1:0] dec_len;
	logic dec_wr;
	logic dec_rmw;

	// Decode from the latched opcode; the opcode cycle itself only captures it
	mode_decode u_dec (
		.opcode(op_reg),
		.mode(dec_mode),
		.length(dec_len),
		.writes_mem(dec_wr),
		.is_rmw(dec_rmw)
	);

	function automatic logic [2:0] mode_code(input mode_t m);
		case (m)
			MODE_INH: mode_code = 3'h1;
			MODE_IMM: mode_code = 3'h2;
			MODE_DIR: mode_code = 3'h3;
			MODE_EXT: mode_code = 3'h4;
			default: mode_code = 3'h0;
		endcase
	endfunction

	// Operation applied to memory or register operand
	function automatic logic [7:0] alu(input logic [3:0] r, input logic [7:0] a,
		input logic [7:0] m);
		case (r)
			OP_SUB, OP_SBC: alu = 8'(a - m);
			OP_AND: alu = a & m;
			OP_EOR: alu = a ^ m;
			OP_ORA: alu = a | m;
			OP_ADD, OP_ADC: alu = 8'(a + m);
			default: alu = m;
		endcase
	endfunction

	function automatic logic [7:0] rmw(input logic [3:0] r, input logic [7:0] v);
		case (r)
			RMW_NEG: rmw = 8'(BYTE_ZERO - v);
			RMW_COM: rmw = ~v;
			RMW_LSR: rmw = {1'b0, v[7:1]};
			RMW_ROR: rmw = {1'b0, v[7:1]};
			RMW_ASR: rmw = {v[7], v[7:1]};
			RMW_LSL, RMW_ROL: rmw = {v[6:0], 1'b0};
			RMW_DEC: rmw = 8'(v - BYTE_ONE);
			RMW_INC: rmw = 8'(v + BYTE_ONE);
			RMW_CLR: rmw = BYTE_ZERO;
			default: rmw = v;
		endcase
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		logic [7:0] res;
		logic [15:0] ea;
		res = BYTE_ZERO;
		ea = {hi_reg, lo_reg};
		state_next = state_reg;
		pc_next = pc_reg;
		op_next = op_reg;
		hi_next = hi_reg;
		lo_next = lo_reg;
		acc_next = acc_reg;
		x_next = x_reg;
		z_next = z_reg;
		n_next = n_reg;
		addr_next = addr_reg;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		ea_next = ea_reg;
		eav_next = 1'b0;
		mode_next = mode_reg;
		ill_next = 1'b0;
		case (state_reg)
			ST_OPCODE:
			begin
				// Cycle 1: opcode byte arrives at the address presented last cycle
				op_next = mem_rdata;
				pc_next = 16'(pc_reg + PC_STEP);
				addr_next = 16'(pc_reg + PC_STEP);
				rd_next = 1'b1;
				state_next = ST_OPND1;
			end
			ST_OPND1:
			begin
				mode_next = mode_code(dec_mode);
				case (dec_mode)
					MODE_INH:
					begin
						// No program byte consumed; the prefetch is discarded
						addr_next = pc_reg;
						rd_next = 1'b1;
						state_next = ST_EXEC;
					end
					MODE_IMM:
					begin
						// Operand is the byte itself, not an address
						pc_next = 16'(pc_reg + PC_STEP);
						res = alu(op_reg[3:0], acc_reg, mem_rdata);
						if (op_reg[3:0] == OP_LDA)
							acc_next = mem_rdata;
						else if (op_reg[3:0] == OP_LDX)
							x_next = mem_rdata;
						else if ((op_reg[3:0] == OP_CPX))
							res = 8'(x_reg - mem_rdata);
						else if ((op_reg[3:0] != OP_CMP) && (op_reg[3:0] != OP_BIT))
							acc_next = res;
						if (op_reg[3:0] == OP_LDA || op_reg[3:0] == OP_LDX)
							res = mem_rdata;
						z_next = (res == BYTE_ZERO);
						n_next = res[7];
						addr_next = 16'(pc_reg + PC_STEP);
						rd_next = 1'b1;
						state_next = ST_OPCODE;
					end
					MODE_DIR:
					begin
						pc_next = 16'(pc_reg + PC_STEP);
						hi_next = ZERO_PAGE_HI;
						lo_next = mem_rdata;
						state_next = ST_EXEC;
					end
					MODE_EXT:
					begin
						pc_next = 16'(pc_reg + PC_STEP);
						hi_next = mem_rdata;
						addr_next = 16'(pc_reg + PC_STEP);
						rd_next = 1'b1;
						state_next = ST_OPND2;
					end
					default:
					begin
						// Unsupported opcode here: skip it and refetch
						ill_next = 1'b1;
						addr_next = pc_reg;
						rd_next = 1'b1;
						state_next = ST_OPCODE;
					end
				endcase
			end
			ST_OPND2:
			begin
				pc_next = 16'(pc_reg + PC_STEP);
				lo_next = mem_rdata;
				state_next = ST_EXEC;
			end
			ST_EXEC:
			begin
				if (dec_mode == MODE_INH)
				begin
					// Register form: low nibble picks the op, column picks A or X
					res = rmw(op_reg[3:0], (op_reg[7:4] == COL_INH_X) ? x_reg : acc_reg);
					if (op_reg[7:4] == COL_INH_A)
						acc_next = res;
					else if (op_reg[7:4] == COL_INH_X)
						x_next = res;
					if (op_reg[7:4] == COL_INH_A || op_reg[7:4] == COL_INH_X)
					begin
						z_next = (res == BYTE_ZERO);
						n_next = res[7];
					end
					addr_next = pc_reg;
					rd_next = 1'b1;
					state_next = ST_OPCODE;
				end
				else
				begin
					// Effective address presented to memory
					ea_next = ea;
					eav_next = 1'b1;
					addr_next = ea;
					if (dec_wr && !dec_rmw)
					begin
						wr_next = 1'b1;
						wdata_next = (op_reg[3:0] == OP_STX) ? x_reg : acc_reg;
						state_next = ST_EXEC2;
					end
					else if (!dec_rmw && (op_reg[3:0] == OP_JMP))
					begin
						pc_next = ea;
						addr_next = ea;
						rd_next = 1'b1;
						state_next = ST_OPCODE;
					end
					else
					begin
						rd_next = 1'b1;
						state_next = ST_EXEC2;
					end
				end
			end
			ST_EXEC2:
			begin
				if (dec_rmw && dec_wr && !wr_reg)
				begin
					// Memory read-modify-write: write back the modified byte
					wr_next = 1'b1;
					addr_next = addr_reg;
					wdata_next = rmw(op_reg[3:0], mem_rdata);
					state_next = ST_EXEC2;
				end
				else
				begin
					if (rd_reg && !dec_rmw)
					begin
						res = alu(op_reg[3:0], acc_reg, mem_rdata);
						if (op_reg[3:0] == OP_LDA)
							acc_next = mem_rdata;
						else if (op_reg[3:0] == OP_LDX)
							x_next = mem_rdata;
						else if (op_reg[3:0] == OP_CPX)
							res = 8'(x_reg - mem_rdata);
						else if ((op_reg[3:0] != OP_CMP) && (op_reg[3:0] != OP_BIT))
							acc_next = res;
						z_next = (res == BYTE_ZERO);
						n_next = res[7];
					end
					addr_next = pc_reg;
					rd_next = 1'b1;
					state_next = ST_OPCODE;
				end
			end
			default:
				state_next = ST_OPCODE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_OPCODE;
			pc_reg <= PC_RESET;
			op_reg <= BYTE_ZERO;
			hi_reg <= BYTE_ZERO;
			lo_reg <= BYTE_ZERO;
			acc_reg <= BYTE_ZERO;
			x_reg <= BYTE_ZERO;
			z_reg <= 1'b0;
			n_reg <= 1'b0;
			addr_reg <= PC_RESET;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= BYTE_ZERO;
			ea_reg <= PC_RESET;
			eav_reg <= 1'b0;
			mode_reg <= 3'h0;
			ill_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			op_reg <= op_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
			acc_reg <= acc_next;
			x_reg <= x_next;
			z_reg <= z_next;
			n_reg <= n_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			ea_reg <= ea_next;
			eav_reg <= eav_next;
			mode_reg <= mode_next;
			ill_reg <= ill_next;
		end
	end

	assign mem_addr = addr_reg;
	assign mem_rd = rd_reg;
	assign mem_wr = wr_reg;
	assign mem_wdata = wdata_reg;
	assign pc = pc_reg;
	assign acc = acc_reg;
	assign index_x = x_reg;
	assign flag_z = z_reg;
	assign flag_n = n_reg;
	assign eff_addr = ea_reg;
	assign eff_valid = eav_reg;
	assign cur_mode = mode_reg;
	assign illegal_op = ill_reg;
endmodule

/* File: inc/opfetch_pkg.sv */
// Constants and types shared by the operand fetch and address formation logic
package opfetch_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam int BASE_OPS = 62;
	localparam int OPCODE_COUNT = 210;
	// Opcode column (high nibble) selects mode for the accumulator/memory groups
	localparam logic [3:0] COL_IMM = 4'hA;
	localparam logic [3:0] COL_DIR = 4'hB;
	localparam logic [3:0] COL_EXT = 4'hC;
	localparam logic [3:0] COL_RMW_DIR = 4'h3;
	localparam logic [3:0] COL_INH_A = 4'h4;
	localparam logic [3:0] COL_INH_X = 4'h5;
	localparam logic [3:0] COL_BIT_DIR = 4'h1;
	localparam logic [3:0] COL_BRBIT_DIR = 4'h0;
	localparam logic [3:0] COL_INH_MISC8 = 4'h8;
	localparam logic [3:0] COL_INH_MISC9 = 4'h9;
	localparam logic [3:0] COL_MUL = 4'h4;
	// Low nibble operation codes in the register/memory columns
	localparam logic [3:0] OP_SUB = 4'h0;
	localparam logic [3:0] OP_CMP = 4'h1;
	localparam logic [3:0] OP_SBC = 4'h2;
	localparam logic [3:0] OP_CPX = 4'h3;
	localparam logic [3:0] OP_AND = 4'h4;
	localparam logic [3:0] OP_BIT = 4'h5;
	localparam logic [3:0] OP_LDA = 4'h6;
	localparam logic [3:0] OP_STA = 4'h7;
	localparam logic [3:0] OP_EOR = 4'h8;
	localparam logic [3:0] OP_ADC = 4'h9;
	localparam logic [3:0] OP_ORA = 4'hA;
	localparam logic [3:0] OP_ADD = 4'hB;
	localparam logic [3:0] OP_JMP = 4'hC;
	localparam logic [3:0] OP_JSR = 4'hD;
	localparam logic [3:0] OP_LDX = 4'hE;
	localparam logic [3:0] OP_STX = 4'hF;
	// Read-modify-write low nibbles
	localparam logic [3:0] RMW_NEG = 4'h0;
	localparam logic [3:0] RMW_COM = 4'h3;
	localparam logic [3:0] RMW_LSR = 4'h4;
	localparam logic [3:0] RMW_ROR = 4'h6;
	localparam logic [3:0] RMW_ASR = 4'h7;
	localparam logic [3:0] RMW_LSL = 4'h8;
	localparam logic [3:0] RMW_ROL = 4'h9;
	localparam logic [3:0] RMW_DEC = 4'hA;
	localparam logic [3:0] RMW_INC = 4'hC;
	localparam logic [3:0] RMW_TST = 4'hD;
	localparam logic [3:0] RMW_CLR = 4'hF;
	typedef enum {MODE_ILLEGAL, MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT} mode_t;
	typedef enum {ST_OPCODE, ST_OPND1, ST_OPND2, ST_EXEC, ST_EXEC2} fetch_state_t;
endpackage
